/* File: logic/cpu_exec_core.sv */
// execution unit: takes one decoded instruction, runs it for its clock count
// assumes a decoder feeds instr_i with valid/ready and wake_i is an async pin
`timescale 1ns/1ps
`include "cpu_exec_defs.svh"
module cpu_exec_core #(
	parameter int DATA_AW = 8
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic instr_valid_i,
	input wire cpu_exec_pkg::instr_t instr_i,
	output logic ready_o,
	output logic done_o,
	output logic illegal_o,
	output logic halt_o,
	output logic [15:0] pc_o,
	output logic [7:0] psw_o,
	input wire logic wake_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o
);
	import cpu_exec_pkg::*;
	core_t s;
	core_t next_s;
	logic [7:0] mem [2**DATA_AW];
	logic cpu_en;
	logic [7:0] tim;
	logic [15:0] ea, rp_val, ax, hl, seq, target, word_res;
	logic [7:0] mem_rd, stk0, stk1, stk2, acc, dec_val;
	logic [7:0] a8, b8, res8;
	logic cin8, sub8, z8, ac8, cy8, z16, ac16, cy16;
	logic [2:0] rp_hi, rp_lo;
	logic bus_we, we0, we1;
	logic [7:0] wd0, wd1;
	logic [15:0] wa0, wa1;

	function automatic logic [7:0] op_timing(input op_t op);
		unique case (op)
			op_nop: return `T_NOP;
			op_word_move_imm: return `T_WMOVE_IMM;
			op_word_move_ax_rp: return `T_WMOVE_AX_RP;
			op_word_move_rp_ax: return `T_WMOVE_RP_AX;
			op_word_exchange: return `T_WEXCH;
			op_add_saddr_imm: return `T_ADD_SADDR;
			op_add_with_carry_abs: return `T_ADDCY_ABS;
			op_sub_hl_offset: return `T_SUB_HLOFF;
			op_subtract_with_borrow_abs: return `T_SUBBR_ABS;
			op_or_saddr_imm: return `T_OR_SADDR;
			op_inc_saddr: return `T_INC_SADDR;
			op_inc_pair: return `T_INC_PAIR;
			op_cmp_imm: return `T_CMP_IMM;
			op_cmp_word, op_add_word, op_sub_word: return `T_WORD_ARITH;
			op_call: return `T_CALL;
			op_ret: return `T_RET;
			op_return_from_interrupt: return `T_RET_INT;
			op_pop_psw: return `T_POP_PSW;
			op_push_psw: return `T_PUSH_PSW;
			op_branch_on_carry, op_branch_not_zero: return `T_BRANCH_REL;
			op_branch_bit_true, op_branch_bit_false: return `T_BRANCH_BIT;
			op_decrement_branch_nonzero: return `T_DEC_BRANCH;
			op_interrupt_enable_instr, op_interrupt_disable: return `T_INT_CTRL;
			op_halt: return `T_HALT;
			default: return `T_NOP;
		endcase
	endfunction

	cpu_clock_divider u_div (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.sel_i(s.div_sel),
		.en_o(cpu_en)
	);

	arith_unit #(.W(8)) u_alu8 (
		.a_i(a8),
		.b_i(b8),
		.cin_i(cin8),
		.sub_i(sub8),
		.res_o(res8),
		.z_o(z8),
		.half_o(ac8),
		.carry_o(cy8)
	);

	// word arithmetic: nibble carry taken from the low nibble
	arith_unit #(.W(16)) u_alu16 (
		.a_i(ax),
		.b_i(s.ins.word),
		.cin_i(1'b0),
		.sub_i(s.ins.op != op_add_word),
		.res_o(word_res),
		.z_o(z16),
		.half_o(ac16),
		.carry_o(cy16)
	);

	// operand fetch for the latched instruction
	always_comb begin
		tim = op_timing(s.ins.op);
		rp_hi = {s.ins.sel[1:0], 1'b1};
		rp_lo = {s.ins.sel[1:0], 1'b0};
		rp_val = {s.gpr[rp_hi], s.gpr[rp_lo]};
		ax = {s.gpr[`GPR_A], s.gpr[`GPR_X]};
		hl = {s.gpr[`GPR_H], s.gpr[`GPR_L]};
		acc = s.gpr[`GPR_A];
		ea = (s.ins.op == op_sub_hl_offset) ? hl + {8'h00, s.ins.imm} : s.ins.word;
		mem_rd = mem[ea[DATA_AW-1:0]];
		stk0 = mem[s.sp[DATA_AW-1:0]];
		stk1 = mem[DATA_AW'(s.sp + 16'h0001)];
		stk2 = mem[DATA_AW'(s.sp + 16'h0002)];
		seq = s.pc + {12'h000, tim[7:4]};
		target = seq + {{8{s.ins.disp[7]}}, s.ins.disp};
		dec_val = s.gpr[s.ins.sel[0] ? `GPR_C : `GPR_B] - 8'h01;
		a8 = acc;
		b8 = mem_rd;
		cin8 = 1'b0;
		sub8 = 1'b0;
		unique case (s.ins.op)
			op_add_saddr_imm: begin
				a8 = mem_rd;
				b8 = s.ins.imm;
			end
			op_add_with_carry_abs: cin8 = s.program_status_word[`PSW_CARRY];
			op_sub_hl_offset: sub8 = 1'b1;
			op_subtract_with_borrow_abs: begin
				cin8 = s.program_status_word[`PSW_CARRY];
				sub8 = 1'b1;
			end
			op_inc_saddr: begin
				a8 = mem_rd;
				b8 = 8'h01;
			end
			op_cmp_imm: begin
				b8 = s.ins.imm;
				sub8 = 1'b1;
			end
			default: ;
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.illegal = 1'b0;
		next_s.wake_sync = {s.wake_sync[0], wake_i};
		bus_we = 1'b0;
		we0 = 1'b0;
		we1 = 1'b0;
		wa0 = ea;
		wa1 = s.sp - 16'h0002;
		wd0 = res8;
		wd1 = 8'h00;
		if (wr_i) begin
			unique case (addr_i)
				`REG_CLKSEL: next_s.div_sel = wdata_i[1:0];
				`REG_MEM_PTR: next_s.mem_ptr = wdata_i;
				`REG_MEM_DATA: bus_we = 1'b1;
				default: ;
			endcase
		end
		if (rd_i) begin
			unique case (addr_i)
				`REG_CLKSEL: next_s.rdata = {6'h00, s.div_sel};
				`REG_PSW: next_s.rdata = s.program_status_word;
				`REG_PC_LO: next_s.rdata = s.pc[7:0];
				`REG_PC_HI: next_s.rdata = s.pc[15:8];
				`REG_ACC: next_s.rdata = acc;
				`REG_B: next_s.rdata = s.gpr[`GPR_B];
				`REG_C: next_s.rdata = s.gpr[`GPR_C];
				`REG_RUN: next_s.rdata = {6'h00, s.st == st_halt, s.st != st_idle};
				`REG_MEM_PTR: next_s.rdata = s.mem_ptr;
				`REG_MEM_DATA: next_s.rdata = mem[s.mem_ptr[DATA_AW-1:0]];
				`REG_SP_LO: next_s.rdata = s.sp[7:0];
				`REG_SP_HI: next_s.rdata = s.sp[15:8];
				default: next_s.rdata = 8'h00;
			endcase
		end
		unique case (s.st)
			st_idle: begin
				if (instr_valid_i) begin
					// accumulator pair as the other operand is refused
					if ((instr_i.op == op_word_move_ax_rp || instr_i.op == op_word_move_rp_ax ||
						instr_i.op == op_word_exchange) && instr_i.sel[1:0] == `RP_AX) begin
						next_s.illegal = 1'b1;
						next_s.done = 1'b1;
					end else begin
						next_s.ins = instr_i;
						next_s.cnt = 4'(op_timing(instr_i.op) - 8'h01);
						next_s.st = st_exec;
					end
				end
			end
			st_exec: begin
				// one count per cpu clock enable, never per system clock
				if (cpu_en) begin
					if (s.cnt != 4'h0) begin
						next_s.cnt = s.cnt - 4'h1;
					end else begin
						next_s.done = 1'b1;
						next_s.st = st_idle;
						next_s.pc = seq;
						unique case (s.ins.op)
							op_word_move_imm: begin
								next_s.gpr[rp_hi] = s.ins.word[15:8];
								next_s.gpr[rp_lo] = s.ins.word[7:0];
							end
							op_word_move_ax_rp: begin
								next_s.gpr[`GPR_A] = rp_val[15:8];
								next_s.gpr[`GPR_X] = rp_val[7:0];
							end
							op_word_move_rp_ax: begin
								next_s.gpr[rp_hi] = ax[15:8];
								next_s.gpr[rp_lo] = ax[7:0];
							end
							op_word_exchange: begin
								next_s.gpr[`GPR_A] = rp_val[15:8];
								next_s.gpr[`GPR_X] = rp_val[7:0];
								next_s.gpr[rp_hi] = ax[15:8];
								next_s.gpr[rp_lo] = ax[7:0];
							end
							op_add_saddr_imm, op_inc_saddr: begin
								we0 = 1'b1;
								next_s.program_status_word[`PSW_Z] = z8;
								next_s.program_status_word[`PSW_HALF] = ac8;
								// increment leaves carry alone
								if (s.ins.op == op_add_saddr_imm) begin
									next_s.program_status_word[`PSW_CARRY] = cy8;
								end
							end
							op_add_with_carry_abs, op_sub_hl_offset, op_subtract_with_borrow_abs,
							op_cmp_imm: begin
								// compare keeps the accumulator
								if (s.ins.op != op_cmp_imm) begin
									next_s.gpr[`GPR_A] = res8;
								end
								next_s.program_status_word[`PSW_Z] = z8;
								next_s.program_status_word[`PSW_HALF] = ac8;
								next_s.program_status_word[`PSW_CARRY] = cy8;
							end
							op_or_saddr_imm: begin
								we0 = 1'b1;
								wd0 = mem_rd | s.ins.imm;
								next_s.program_status_word[`PSW_Z] = ((mem_rd | s.ins.imm) == 8'h00);
							end
							op_inc_pair: begin
								// no flag touched by the pair increment
								next_s.gpr[rp_hi] = 8'(({rp_val} + 16'h0001) >> 8);
								next_s.gpr[rp_lo] = rp_val[7:0] + 8'h01;
							end
							op_cmp_word, op_add_word, op_sub_word: begin
								if (s.ins.op != op_cmp_word) begin
									next_s.gpr[`GPR_A] = word_res[15:8];
									next_s.gpr[`GPR_X] = word_res[7:0];
								end
								next_s.program_status_word[`PSW_Z] = z16;
								next_s.program_status_word[`PSW_HALF] = ac16;
								next_s.program_status_word[`PSW_CARRY] = cy16;
							end
							op_call: begin
								we0 = 1'b1;
								wa0 = s.sp - 16'h0001;
								wd0 = seq[15:8];
								we1 = 1'b1;
								wd1 = seq[7:0];
								next_s.sp = s.sp - 16'h0002;
								next_s.pc = s.ins.word;
							end
							op_ret, op_return_from_interrupt: begin
								next_s.pc = {stk1, stk0};
								next_s.sp = s.sp + 16'h0002;
								if (s.ins.op == op_return_from_interrupt) begin
									next_s.program_status_word = stk2;
									next_s.sp = s.sp + 16'h0003;
								end
							end
							op_pop_psw: begin
								next_s.program_status_word = stk0;
								next_s.sp = s.sp + 16'h0001;
							end
							op_push_psw: begin
								we1 = 1'b1;
								wa1 = s.sp - 16'h0001;
								wd1 = s.program_status_word;
								next_s.sp = s.sp - 16'h0001;
							end
							op_branch_on_carry: begin
								if (s.program_status_word[`PSW_CARRY]) next_s.pc = target;
							end
							op_branch_not_zero: begin
								if (!s.program_status_word[`PSW_Z]) next_s.pc = target;
							end
							op_branch_bit_true: begin
								if (mem_rd[s.ins.sel]) next_s.pc = target;
							end
							op_branch_bit_false: begin
								if (!s.program_status_word[s.ins.sel]) next_s.pc = target;
							end
							op_decrement_branch_nonzero: begin
								next_s.gpr[s.ins.sel[0] ? `GPR_C : `GPR_B] = dec_val;
								if (dec_val != 8'h00) next_s.pc = target;
							end
							op_interrupt_enable_instr: next_s.program_status_word[`PSW_INTEN] = 1'b1;
							op_interrupt_disable: next_s.program_status_word[`PSW_INTEN] = 1'b0;
							op_halt: next_s.st = st_halt;
							default: ;
						endcase
					end
				end
			end
			st_halt: begin
				// standby is left only by the synchronised wake level
				if (s.wake_sync[1]) next_s.st = st_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s <= '0;
			s.st <= st_idle;
			s.pc <= `PC_RST;
			s.sp <= `SP_RST;
			s.program_status_word <= `PSW_RST;
		end else begin
			s <= next_s;
		end
	end

	// memory has no reset; execution writes win over a same-cycle bus write
	always_ff @(posedge clk_sys_i) begin
		if (bus_we) mem[s.mem_ptr[DATA_AW-1:0]] <= wdata_i;
		if (we0) mem[wa0[DATA_AW-1:0]] <= wd0;
		if (we1) mem[wa1[DATA_AW-1:0]] <= wd1;
	end

	assign ready_o = (s.st == st_idle);
	assign done_o = s.done;
	assign illegal_o = s.illegal;
	assign halt_o = (s.st == st_halt);
	assign pc_o = s.pc;
	assign psw_o = s.program_status_word;
	assign rdata_o = s.rdata;
endmodule // cpu_exec_core

/* File: logic/cpu_exec_defs.svh */
// named constants of the execution unit: register offsets, psw fields, timing
// assumes inclusion by bare name from the design files
// Summary of operation
// - instruction clocks count selected cpu clock enables
// - one-byte word forms refuse the accumulator pair
// - add immediate to short address, write back
// - add-with-carry absolute: memory plus old carry
// - subtract byte at HL plus offset
// - subtract-with-borrow absolute: memory and old carry
// - or immediate into short address, zero only
// - increment short byte keeps carry; pair increment flagless
// - call pushes return address, sp minus two
// - branch on carry: pc plus two plus displacement
// - branch not zero: jump when zero clear
// - bit-true on short address: pc plus four
// - bit-false on psw bit: pc plus four
// - interrupt enable instruction sets enable flag
// - halt enters standby, one byte, two clocks
`ifndef CPU_EXEC_DEFS_SVH
`define CPU_EXEC_DEFS_SVH
`define REG_CLKSEL 4'h0
`define REG_PSW 4'h1
`define REG_PC_LO 4'h2
`define REG_PC_HI 4'h3
`define REG_ACC 4'h4
`define REG_B 4'h5
`define REG_C 4'h6
`define REG_RUN 4'h7
`define REG_MEM_PTR 4'h8
`define REG_MEM_DATA 4'h9
`define REG_SP_LO 4'hA
`define REG_SP_HI 4'hB
`define PSW_INTEN 7
`define PSW_Z 6
`define PSW_HALF 4
`define PSW_CARRY 0
`define PSW_RST 8'h00
`define SP_RST 16'hFF00
`define PC_RST 16'h0000
`define GPR_X 3'h0
`define GPR_A 3'h1
`define GPR_C 3'h2
`define GPR_B 3'h3
`define GPR_L 3'h6
`define GPR_H 3'h7
`define RP_AX 2'h0
// timing: upper nibble bytes, lower nibble cpu clocks
`define T_NOP 8'h12
`define T_WMOVE_IMM 8'h36
`define T_WMOVE_AX_RP 8'h14
`define T_WMOVE_RP_AX 8'h14
`define T_WEXCH 8'h18
`define T_ADD_SADDR 8'h36
`define T_ADDCY_ABS 8'h38
`define T_SUB_HLOFF 8'h26
`define T_SUBBR_ABS 8'h38
`define T_OR_SADDR 8'h36
`define T_INC_SADDR 8'h24
`define T_INC_PAIR 8'h14
`define T_CMP_IMM 8'h24
`define T_WORD_ARITH 8'h36
`define T_CALL 8'h36
`define T_RET 8'h16
`define T_RET_INT 8'h18
`define T_POP_PSW 8'h14
`define T_PUSH_PSW 8'h12
`define T_BRANCH_REL 8'h26
`define T_BRANCH_BIT 8'h4A
`define T_DEC_BRANCH 8'h26
`define T_INT_CTRL 8'h36
`define T_HALT 8'h12
`define DIV_MAX 3'h7
`endif

/* File: logic/cpu_exec_pkg.sv */
// types shared by the execution unit and its helpers
// assumes nothing beyond a SystemVerilog compiler
package cpu_exec_pkg;
	typedef enum logic [4:0] {
		op_nop, op_word_move_imm, op_word_move_ax_rp, op_word_move_rp_ax, op_word_exchange,
		op_add_saddr_imm, op_add_with_carry_abs, op_sub_hl_offset, op_subtract_with_borrow_abs,
		op_or_saddr_imm, op_inc_saddr, op_inc_pair, op_cmp_imm, op_cmp_word, op_add_word,
		op_sub_word, op_call, op_ret, op_return_from_interrupt, op_pop_psw, op_push_psw,
		op_branch_on_carry, op_branch_not_zero, op_branch_bit_true, op_branch_bit_false,
		op_decrement_branch_nonzero, op_interrupt_enable_instr, op_interrupt_disable, op_halt
	} op_t;
	typedef struct packed {
		op_t op;
		logic [2:0] sel;
		logic [7:0] imm;
		logic [15:0] word;
		logic [7:0] disp;
	} instr_t;
	typedef enum logic [1:0] {st_idle = 2'b00, st_exec = 2'b01, st_halt = 2'b11} cpu_state_t;
	typedef struct packed {
		cpu_state_t st;
		logic [3:0] cnt;
		instr_t ins;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [7:0][7:0] gpr;
		logic [7:0] program_status_word;
		logic [1:0] div_sel;
		logic [7:0] mem_ptr;
		logic [7:0] rdata;
		logic done;
		logic illegal;
		logic [1:0] wake_sync;
	} core_t;
	typedef struct packed {
		logic [2:0] cnt;
		logic en;
	} div_t;
endpackage

/* File: logic/cpu_clock_divider.sv */
// cpu clock enable: one pulse every 1, 2, 4 or 8 system clocks
// assumes the select comes from logic on the same clock
`timescale 1ns/1ps
module cpu_clock_divider (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] sel_i,
	output logic en_o
);
	import cpu_exec_pkg::*;
	div_t s;
	div_t next_s;
	logic [2:0] mask;
	always_comb begin
		mask = 3'((4'h1 << sel_i) - 4'h1);
		next_s = s;
		next_s.cnt = (s.cnt == `DIV_MAX) ? 3'h0 : s.cnt + 3'h1;
		next_s.en = ((s.cnt & mask) == 3'h0);
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign en_o = s.en;
endmodule // cpu_clock_divider

/* File: logic/arith_unit.sv */
// add or subtract with carry in, giving zero, nibble carry and carry/borrow
// assumes operands are stable in the cycle the result is used
`timescale 1ns/1ps
module arith_unit #(
	parameter int W = 8
) (
	input wire logic [W-1:0] a_i,
	input wire logic [W-1:0] b_i,
	input wire logic cin_i,
	input wire logic sub_i,
	output logic [W-1:0] res_o,
	output logic z_o,
	output logic half_o,
	output logic carry_o
);
	logic [W-1:0] bx;
	logic ci;
	logic [W:0] full;
	logic [4:0] low;
	// subtraction as a + ~b + ~borrow; carry out inverted is the borrow
	always_comb begin
		bx = sub_i ? ~b_i : b_i;
		ci = sub_i ? ~cin_i : cin_i;
		full = {1'b0, a_i} + {1'b0, bx} + {{W{1'b0}}, ci};
		low = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
		res_o = full[W-1:0];
		z_o = (full[W-1:0] == '0);
		half_o = low[4] ^ sub_i;
		carry_o = full[W] ^ sub_i;
	end
endmodule // arith_unit

/* File: bench/cpu_exec_core_sva.sv */
// checker for the execution core, watching its instruction and register ports
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
`include "cpu_exec_defs.svh"
module cpu_exec_core_sva #(
	parameter int DATA_AW = 8
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic instr_valid_i,
	input wire cpu_exec_pkg::instr_t instr_i,
	input wire logic ready_o,
	input wire logic done_o,
	input wire logic illegal_o,
	input wire logic halt_o,
	input wire logic [15:0] pc_o,
	input wire logic [7:0] psw_o,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i
);
	import cpu_exec_pkg::*;
	logic take;
	logic [1:0] k;
	op_t last;
	assign take = ready_o && instr_valid_i;
	// divide setting tracked, exact counts only hold at divide by one
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			k <= 2'h0;
			last <= op_nop;
		end else begin
			if (wr_i && addr_i == `REG_CLKSEL) k <= wdata_i[1:0];
			if (take) last <= instr_i.op;
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_illegal_with_done: assert property (illegal_o |-> done_o)
		else $error("illegal flag without done");
	a_done_single: assert property (done_o |=> !done_o)
		else $error("done longer than one cycle");
	a_add_saddr_time: assert property (take && k == 2'h0 && instr_i.op == op_add_saddr_imm
		|=> (!ready_o)[*6] ##1 (done_o && ready_o)) else $error("add to short address timing");
	a_halt_entry: assert property (take && k == 2'h0 && instr_i.op == op_halt
		|=> (!halt_o)[*2] ##1 halt_o) else $error("standby entry timing");
	a_halt_blocks: assert property (halt_o |-> !ready_o)
		else $error("ready while in standby");
	a_call_target: assert property (take && k == 2'h0 && instr_i.op == op_call
		|-> ##7 pc_o == $past(instr_i.word, 7)) else $error("call target wrong");
	a_ie_set: assert property (done_o && last == op_interrupt_enable_instr
		|-> psw_o[`PSW_INTEN]) else $error("enable flag not set");
	a_pair_inc_flags: assert property (done_o && last == op_inc_pair |-> $stable(psw_o))
		else $error("pair increment changed flags");
	a_or_keeps_carry: assert property (done_o && last == op_or_saddr_imm
		|-> $stable(psw_o[`PSW_CARRY]) && $stable(psw_o[`PSW_HALF])) else $error("or changed carries");
	a_branch_fall: assert property (done_o && last == op_branch_on_carry && !psw_o[`PSW_CARRY]
		|-> pc_o == $past(pc_o) + 16'h0002) else $error("carry branch taken wrongly");
endmodule // cpu_exec_core_sva
bind cpu_exec_core cpu_exec_core_sva #(.DATA_AW(DATA_AW)) u_chk (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .instr_valid_i(instr_valid_i),
	.instr_i(instr_i), .ready_o(ready_o), .done_o(done_o), .illegal_o(illegal_o),
	.halt_o(halt_o), .pc_o(pc_o), .psw_o(psw_o), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i));

/* File: bench/cpu_exec_core_test.sv */
// self-checking bench for the execution core with an integer model
// assumes the core is reached only through its instruction and register ports
`timescale 1ns/1ps
`include "cpu_exec_defs.svh"
module cpu_exec_core_test;
	import cpu_exec_pkg::*;
	logic clk_sys_i = 0;
	logic sys_rst_i = 1;
	logic instr_valid_i = 0;
	instr_t instr_i = '0;
	logic wake_i = 0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 0;
	logic rd_i = 0;
	logic ready_o, done_o, illegal_o, halt_o, ill;
	logic [15:0] pc_o;
	logic [7:0] psw_o, rdata_o, rv, d;
	int error_cnt = 0;
	int tests_run = 0;
	int mpc = 0, ma = 0, mz = 0, mac = 0, mcy = 0, mie = 0, kk = 0;
	int r, x, y, i, s, t, lat;
	op_t wop[3] = '{op_word_move_ax_rp, op_word_move_rp_ax, op_word_exchange};
	int wn[3] = '{4, 4, 8};
	always #10 clk_sys_i = ~clk_sys_i;
	cpu_exec_core DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.instr_valid_i(instr_valid_i), .instr_i(instr_i), .ready_o(ready_o), .done_o(done_o),
		.illegal_o(illegal_o), .halt_o(halt_o), .pc_o(pc_o), .psw_o(psw_o), .wake_i(wake_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_lat(input int got, input int lo, input int hi);
		tests_run++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("ERROR %0t latency %0d", $time, got);
		end
	endtask
	function automatic logic [7:0] ps();
		return {mie[0], mz[0], 1'b0, mac[0], 3'b000, mcy[0]};
	endfunction
	function automatic int rel(input int o);
		return mpc + o + $signed(d);
	endfunction
	task automatic alu(input int a, input int b, input int ci, input int sub);
		r = sub ? a - b - ci : a + b + ci;
		mcy = (r >> 8) & 1;
		mac = sub ? ((a & 15) - (b & 15) - ci) < 0 : ((a & 15) + (b & 15) + ci) > 15;
		r = r & 255;
		mz = r == 0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task automatic rchk(input logic [3:0] a, input int e);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		chk({8'h00, rdata_o}, e[15:0]);
	endtask
	task automatic mset(input logic [7:0] a, input logic [7:0] v);
		wr(`REG_MEM_PTR, a);
		wr(`REG_MEM_DATA, v);
	endtask
	task automatic mchk(input logic [7:0] a, input int e);
		wr(`REG_MEM_PTR, a);
		rchk(`REG_MEM_DATA, e);
	endtask
	// caller sets the model's pc and flags first; n of 0 skips the timing check
	task automatic exe(input op_t op, input logic [2:0] sl, input logic [7:0] im,
		input logic [15:0] w, input logic [7:0] dp, input int n);
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{op, sl, im, w, dp};
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b0;
		lat = 0;
		do begin
			@(negedge clk_sys_i);
			lat++;
		end while (done_o !== 1'b1 && lat < 300);
		if (lat >= 300) begin
			error_cnt++;
			final_report();
		end
		ill = illegal_o;
		if (n > 0) chk_lat(lat, (n - 1) * (1 << kk) + 2, n * (1 << kk) + 1);
		chk(pc_o, mpc[15:0]);
		chk({8'h00, psw_o}, {8'h00, ps()});
	endtask
	initial begin
		void'($urandom(56000));
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		// memory has no reset value; its pointer resets to 0 but is skipped too
		for (i = 0; i < 16; i++) begin
			if (i != 8 && i != 9) rchk(i[3:0], i == 11 ? 'hFF : 0);
		end
		$display("reset values done");
		for (i = 0; i < 3; i++) begin
			for (s = 0; s < 4; s++) begin
				if (s > 0) mpc++;
				exe(wop[i], s[2:0], 8'h00, 16'h0000, 8'h00, s > 0 ? wn[i] : 0);
				chk({15'h0000, ill}, {15'h0000, s == 0});
			end
		end
		mpc += 3;
		exe(op_word_move_imm, 3'h3, 8'h00, 16'h0010, 8'h00, 6);
		$display("word forms done");
		for (i = 0; i < 6; i++) begin
			x = $urandom % 256;
			y = $urandom % 256;
			mset(8'h20, x[7:0]);
			alu(x, y, 0, 0);
			mpc += 3;
			exe(op_add_saddr_imm, 3'h0, y[7:0], 16'hFE20, 8'h00, 6);
			mchk(8'h20, r);
			mset(8'h30, y[7:0]);
			alu(ma, y, mcy, 0);
			ma = r;
			mpc += 3;
			exe(op_add_with_carry_abs, 3'h0, 8'h00, 16'h0030, 8'h00, 8);
			mset(8'h15, x[7:0]);
			alu(ma, x, 0, 1);
			ma = r;
			mpc += 2;
			exe(op_sub_hl_offset, 3'h0, 8'h05, 16'h0000, 8'h00, 6);
			mset(8'h31, y[7:0]);
			alu(ma, y, mcy, 1);
			ma = r;
			mpc += 3;
			exe(op_subtract_with_borrow_abs, 3'h0, 8'h00, 16'h0031, 8'h00, 8);
			rchk(`REG_ACC, ma);
			mset(8'h21, x[7:0]);
			mz = (x | y) == 0;
			mpc += 3;
			exe(op_or_saddr_imm, 3'h0, y[7:0], 16'hFE21, 8'h00, 6);
			mchk(8'h21, x | y);
		end
		mset(8'h22, 8'hFF);
		mz = 1;
		mac = 1;
		mpc += 2;
		exe(op_inc_saddr, 3'h0, 8'h00, 16'hFE22, 8'h00, 4);
		mchk(8'h22, 0);
		mpc += 1;
		exe(op_inc_pair, 3'h3, 8'h00, 16'h0000, 8'h00, 4);
		$display("arithmetic done");
		// accumulator and B/C are read-only on the port: load them by word moves
		mpc += 3;
		exe(op_word_move_imm, 3'h0, 8'h00, 16'h4000, 8'h00, 6);
		for (i = 0; i < 2; i++) begin
			alu('h40, 'h40 + i, 0, 1);
			mpc += 2;
			exe(op_cmp_imm, 3'h0, 8'h40 + i[7:0], 16'h0000, 8'h00, 4);
			rchk(`REG_ACC, 'h40);
			d = 8'($urandom);
			mpc = mcy ? rel(2) : mpc + 2;
			exe(op_branch_on_carry, 3'h0, 8'h00, 16'h0000, d, 6);
			d = 8'($urandom);
			mpc = mz ? mpc + 2 : rel(2);
			exe(op_branch_not_zero, 3'h0, 8'h00, 16'h0000, d, 6);
		end
		mpc += 3;
		exe(op_word_move_imm, 3'h1, 8'h00, 16'h0102, 8'h00, 6);
		for (s = 0; s < 2; s++) begin
			d = 8'($urandom);
			mpc = s ? rel(2) : mpc + 2;
			exe(op_decrement_branch_nonzero, s[2:0], 8'h00, 16'h0000, d, 6);
			rchk(`REG_B + s[3:0], s);
		end
		mie = 1;
		mpc += 3;
		exe(op_interrupt_enable_instr, 3'h0, 8'h00, 16'h0000, 8'h00, 6);
		x = $urandom % 256;
		mset(8'h40, x[7:0]);
		for (s = 0; s < 8; s++) begin
			d = 8'($urandom);
			mpc = x[s] ? rel(4) : mpc + 4;
			exe(op_branch_bit_true, s[2:0], 8'h00, 16'hFE40, d, 10);
			d = 8'($urandom);
			t = ps();
			mpc = t[s] ? mpc + 4 : rel(4);
			exe(op_branch_bit_false, s[2:0], 8'h00, 16'h0000, d, 10);
		end
		$display("branches done");
		x = $urandom % 65536;
		y = mpc + 3;
		mpc = x;
		exe(op_call, 3'h0, 8'h00, x[15:0], 8'h00, 6);
		mchk(8'hFF, (y >> 8) & 255);
		mchk(8'hFE, y & 255);
		rchk(`REG_SP_LO, 'hFE);
		x = $urandom % 65536;
		mset(8'hFE, x[7:0]);
		mset(8'hFF, x[15:8]);
		mset(8'h00, 8'h51);
		{mie, mz, mac, mcy} = {32'd0, 32'd1, 32'd1, 32'd1};
		mpc = x;
		exe(op_return_from_interrupt, 3'h0, 8'h00, 16'h0000, 8'h00, 8);
		rchk(`REG_SP_LO, 'h01);
		$display("call and return done");
		for (kk = 1; kk < 4; kk++) begin
			wr(`REG_CLKSEL, kk[7:0]);
			rchk(`REG_CLKSEL, kk);
			mpc++;
			exe(op_nop, 3'h0, 8'h00, 16'h0000, 8'h00, 2);
		end
		kk = 0;
		wr(`REG_CLKSEL, 8'h00);
		$display("clock divide done");
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{op_halt, 3'h0, 8'h00, 16'h0000, 8'h00};
		@(posedge clk_sys_i);
		instr_valid_i <= 1'b0;
		repeat (3) @(negedge clk_sys_i);
		chk({14'h0000, ready_o, halt_o}, 16'h0001);
		@(posedge clk_sys_i);
		wake_i <= 1'b1;
		lat = 0;
		while (ready_o !== 1'b1 && lat < 50) begin
			@(negedge clk_sys_i);
			lat++;
		end
		if (lat >= 50) begin
			error_cnt++;
			final_report();
		end
		@(posedge clk_sys_i);
		wake_i <= 1'b0;
		mpc++;
		@(negedge clk_sys_i);
		chk({15'h0000, halt_o}, 16'h0000);
		chk(pc_o, mpc[15:0]);
		$display("standby done");
		final_report();
	end
endmodule // cpu_exec_core_test
